/* File: rtl/pipe_ctl.sv */
// Dispatch, execute and completion control of a superscalar core
`timescale 1ns/10ps
`include "pipe_ctl_map.svh"

// Function
// - Four stages: fetch, dispatch, execute, complete
// - Completion entry reserved at dispatch
// - One stage per instruction; advance or stall
// - Fold branches not writing count or link
// - Taken branch redirects fetch, else sequential
// - Dispatch from two oldest queue entries
// - Need station, rename buffer, completion entry
// - Up to two dispatched per cycle
// - Rename destination; tag pending sources
// - Issued leave queue, entries in order
// - Integer ops finish in one cycle
// - Float stages multiply, add, normalize
// - Single precision: throughput one, latency three
// - Double multiply: throughput two, latency four
// - Divide holds first float stage, blocks younger float ops
// - Load/store: two stations, two stages
// - Loads: throughput one, latency two
// - Exception reported; dispatch to every unit halts
// - Exception signalled only when older safe
// - Retire two oldest in order, write back
// - Exception cancels younger, fetch from vector
module pipe_ctl (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Fetched branch from the instruction queue head
  input wire pipe_ctl_pkg::branch_s branch_in,
  // Two oldest instruction queue entries
  input wire pipe_ctl_pkg::instr_s slot0_in,
  input wire pipe_ctl_pkg::instr_s slot1_in,
  // Execution events
  input wire logic fp_div_done_in,
  input wire logic ls_stall_in,
  input wire logic exc_in,
  input wire logic [31:0] exc_vector_in,
  // Fetch control
  output logic [31:0] fetch_pc_out,
  output logic branch_folded_out,
  // Dispatch results
  output logic [1:0] deq_count_out,
  output pipe_ctl_pkg::issue_s issue0_out,
  output pipe_ctl_pkg::issue_s issue1_out,
  // Finish and retirement
  output logic int_done_out,
  output logic fp_done_out,
  output logic ls_done_out,
  output logic [1:0] retire_count_out,
  output logic flush_out
);
  import pipe_ctl_pkg::*;

  // ----------------------------------------
  // Completion queue and rename state
  // ----------------------------------------
  logic [`CQ_DEPTH-1:0] cq_busy_r;
  logic [`CQ_DEPTH-1:0] cq_done_r;
  logic [`CQ_PTR_W-1:0] cq_head_r;
  logic [`CQ_PTR_W-1:0] cq_tail_r;
  logic [`CQ_PTR_W-1:0] cq_cnt_r;
  logic [`RB_COUNT-1:0] rb_busy_r;
  logic [`TAG_W-1:0] rb_of_reg_r [0:31];
  logic [31:0] reg_pend_r;
  // Float pipe: multiply, add, normalize
  logic [2:0] fp_stage_r;
  fp_mode_e fp_mode_r;
  // Load/store: stations, address stage, access stage
  logic [1:0] ls_rs_cnt_r;
  logic ls_ea_r;
  logic ls_acc_r;
  logic int_ex_r;
  logic halt_r;
  logic int_ex1_r;
  logic [`CQ_PTR_W-1:0] int_idx_r;
  logic [`CQ_PTR_W-1:0] int_idx1_r;
  logic [`CQ_PTR_W-1:0] fp_idx_r [0:2];
  logic [`CQ_PTR_W-1:0] ls_rs_idx_r [0:1];
  logic [`CQ_PTR_W-1:0] ls_ea_idx_r;
  logic [`CQ_PTR_W-1:0] ls_acc_idx_r;

  function automatic logic [`CQ_PTR_W-1:0] cq_inc(
      input logic [`CQ_PTR_W-1:0] p);
    cq_inc = (p == `CQ_PTR_W'(`CQ_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  function automatic logic [`TAG_W-1:0] rb_pick(
      input logic [`RB_COUNT-1:0] busy, input logic skip_first);
    logic seen;
    rb_pick = '0;
    seen = 1'b0;
    for (int i = `RB_COUNT - 1; i >= 0; i--) begin
      if (!busy[i]) begin
        rb_pick = `TAG_W'(i);
      end
    end
    if (skip_first) begin
      for (int i = `RB_COUNT - 1; i >= 0; i--) begin
        if (!busy[i] && `TAG_W'(i) != rb_pick && !seen) begin
          rb_pick = `TAG_W'(i);
          seen = 1'b1;
        end
      end
    end
  endfunction

  // ----------------------------------------
  // Dispatch decision
  // ----------------------------------------
  logic [2:0] rb_free;
  logic fp_free, ls_free, ok0, ok1;
  logic [`TAG_W-1:0] tag0, tag1;
  logic [`CQ_PTR_W-1:0] idx1;
  always_comb begin
    rb_free = '0;
    for (int i = 0; i < `RB_COUNT; i++) begin
      rb_free = rb_free + {2'h0, !rb_busy_r[i]};
    end
  end
  assign fp_free = (fp_mode_r == FP_IDLE) && !halt_r;
  assign ls_free = ls_rs_cnt_r < 2'(`LSU_RS_COUNT) && !halt_r;
  function automatic logic unit_ok(input instr_s ins, input logic fpf,
      input logic lsf, input logic hlt);
    unique case (ins.unit)
      UNIT_FP: unit_ok = fpf;
      UNIT_LS: unit_ok = lsf;
      UNIT_INT, UNIT_SYS: unit_ok = !hlt;
    endcase
  endfunction
  assign ok0 = slot0_in.valid && unit_ok(slot0_in, fp_free, ls_free, halt_r)
      && cq_cnt_r < 3'(`CQ_DEPTH) && (!slot0_in.has_dest || rb_free != 0)
      && !flush_out;
  // Second slot only behind the first, one per unit, keeps order
  assign ok1 = ok0 && slot1_in.valid && slot1_in.unit != slot0_in.unit
      && unit_ok(slot1_in, fp_free, ls_free, halt_r)
      && cq_cnt_r < 3'(`CQ_DEPTH - 1)
      && (rb_free >= 3'(32'(slot0_in.has_dest) + 32'(slot1_in.has_dest)));
  assign tag0 = rb_pick(rb_busy_r, 1'b0);
  assign tag1 = rb_pick(rb_busy_r, slot0_in.has_dest);
  assign idx1 = cq_inc(cq_tail_r);

  // ----------------------------------------
  // Fetch and branch folding
  // ----------------------------------------
  // fold plain branches out of stream
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      branch_folded_out <= 1'b0;
    end else begin
      branch_folded_out <= branch_in.valid && !branch_in.writes_cnt_link;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fetch_pc_out <= `PC_RESET;
    end else if (exc_in && halt_r) begin
      fetch_pc_out <= exc_vector_in;
    end else if (branch_in.valid && branch_in.taken) begin
      fetch_pc_out <= branch_in.target;
    end else begin
      fetch_pc_out <= fetch_pc_out + `PC_STEP;
    end
  end

  // ----------------------------------------
  // Issue and rename
  // ----------------------------------------
  // two plus branch; leave queue
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      deq_count_out <= 2'h0;
      issue0_out <= '0;
      issue1_out <= '0;
    end else begin
      deq_count_out <= {1'b0, ok0} + {1'b0, ok1};
      issue0_out <= '0;
      issue1_out <= '0;
      if (ok0) begin
        issue0_out <= '{1'b1, slot0_in.unit, cq_tail_r, tag0,
            reg_pend_r[slot0_in.src], rb_of_reg_r[slot0_in.src]};
      end
      if (ok1) begin
        issue1_out <= '{1'b1, slot1_in.unit, idx1, tag1,
            reg_pend_r[slot1_in.src] || (slot0_in.has_dest
              && slot0_in.dest == slot1_in.src),
            (slot0_in.has_dest && slot0_in.dest == slot1_in.src)
              ? tag0 : rb_of_reg_r[slot1_in.src]};
      end
    end
  end

  // ----------------------------------------
  // Completion queue
  // ----------------------------------------
  logic ret0, ret1;
  logic [`CQ_PTR_W-1:0] head1;
  logic fin_int, fin_fp, fin_ls;
  assign head1 = cq_inc(cq_head_r);
  assign ret0 = cq_busy_r[cq_head_r] && cq_done_r[cq_head_r] && !halt_r;
  assign ret1 = ret0 && cq_busy_r[head1] && cq_done_r[head1];
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || flush_out) begin
      cq_busy_r <= '0;
      cq_head_r <= '0;
      cq_tail_r <= '0;
      cq_cnt_r <= '0;
      retire_count_out <= 2'h0;
    end else begin
      if (ret0) cq_busy_r[cq_head_r] <= 1'b0;
      if (ret1) cq_busy_r[head1] <= 1'b0;
      if (ok0) cq_busy_r[cq_tail_r] <= 1'b1;
      if (ok1) cq_busy_r[idx1] <= 1'b1;
      cq_head_r <= ret1 ? cq_inc(head1) : (ret0 ? head1 : cq_head_r);
      cq_tail_r <= ok1 ? cq_inc(idx1) : (ok0 ? idx1 : cq_tail_r);
      cq_cnt_r <= cq_cnt_r + {2'h0, ok0} + {2'h0, ok1}
          - {2'h0, ret0} - {2'h0, ret1};
      retire_count_out <= {1'b0, ret0} + {1'b0, ret1};
    end
  end
  // each unit marks its own entry
  // Units finish out of order, so the head is not always the finisher
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || flush_out) begin
      cq_done_r <= '0;
    end else begin
      if (ok0) cq_done_r[cq_tail_r] <= 1'b0;
      if (ok1) cq_done_r[idx1] <= 1'b0;
      if (int_ex_r) cq_done_r[int_idx_r] <= 1'b1;
      if (int_ex1_r) cq_done_r[int_idx1_r] <= 1'b1;
      if (fin_fp) cq_done_r[fp_idx_r[2]] <= 1'b1;
      if (fin_ls) cq_done_r[ls_acc_idx_r] <= 1'b1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || flush_out) begin
      rb_busy_r <= '0;
      reg_pend_r <= '0;
      for (int i = 0; i < 32; i++) rb_of_reg_r[i] <= '0;
    end else begin
      if (ret0) rb_busy_r <= '0;
      if (ret0) reg_pend_r <= '0;
      if (ok0 && slot0_in.has_dest) begin
        rb_busy_r[tag0] <= 1'b1;
        reg_pend_r[slot0_in.dest] <= 1'b1;
        rb_of_reg_r[slot0_in.dest] <= tag0;
      end
      if (ok1 && slot1_in.has_dest) begin
        rb_busy_r[tag1] <= 1'b1;
        reg_pend_r[slot1_in.dest] <= 1'b1;
        rb_of_reg_r[slot1_in.dest] <= tag1;
      end
    end
  end

  // ----------------------------------------
  // Execution units
  // ----------------------------------------
  logic fp_in0, fp_in1, ls_in, int_in;
  assign fp_in0 = ok0 && slot0_in.unit == UNIT_FP;
  assign fp_in1 = ok1 && slot1_in.unit == UNIT_FP;
  assign ls_in = (ok0 && slot0_in.unit == UNIT_LS)
      || (ok1 && slot1_in.unit == UNIT_LS);
  logic int_in0, int_in1;
  assign int_in0 = ok0 && slot0_in.unit != UNIT_FP
      && slot0_in.unit != UNIT_LS;
  assign int_in1 = ok1 && slot1_in.unit != UNIT_FP
      && slot1_in.unit != UNIT_LS;
  assign int_in = int_in0 || int_in1;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || flush_out) begin
      int_ex_r <= 1'b0;
      int_ex1_r <= 1'b0;
    end else begin
      int_ex_r <= int_in0;
      int_ex1_r <= int_in1;
    end
  end
  // Integer and system units may both finish in one cycle
  always_ff @(posedge clk_in) begin
    int_idx_r <= cq_tail_r;
    int_idx1_r <= idx1;
  end
  assign fin_int = int_ex_r || int_ex1_r;
  instr_s fp_op;
  assign fp_op = fp_in0 ? slot0_in : slot1_in;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || flush_out) begin
      fp_stage_r <= 3'h0;
      fp_mode_r <= FP_IDLE;
    end else begin
      unique case (fp_mode_r)
        FP_IDLE: begin
          fp_stage_r <= {fp_stage_r[1:0], (fp_in0 || fp_in1)};
          if ((fp_in0 || fp_in1) && fp_op.fp_div) fp_mode_r <= FP_DIV;
          else if ((fp_in0 || fp_in1) && fp_op.fp_double)
            fp_mode_r <= FP_DMUL;
        end
        // Second multiply cycle, stage one held
        FP_DMUL: begin
          fp_stage_r <= {fp_stage_r[1], 1'b0, 1'b1};
          fp_mode_r <= FP_IDLE;
        end
        FP_DIV: begin
          fp_stage_r <= {fp_stage_r[1], 1'b0, 1'b1};
          if (fp_div_done_in) fp_mode_r <= FP_IDLE;
        end
        default: fp_mode_r <= FP_IDLE;
      endcase
    end
  end
  // Stage one held while divide or double multiply repeats
  assign fin_fp = fp_stage_r[2];
  // Entry index rides along with the float stage bits
  always_ff @(posedge clk_in) begin
    if (fp_in0 || fp_in1) fp_idx_r[0] <= fp_in0 ? cq_tail_r : idx1;
    fp_idx_r[1] <= fp_idx_r[0];
    fp_idx_r[2] <= fp_idx_r[1];
  end
  logic ls_ea_take;
  logic [`CQ_PTR_W-1:0] ls_new_idx;
  // Address stage refills unless it is full behind a stalled access
  assign ls_ea_take = !(ls_stall_in && ls_acc_r) || !ls_ea_r;
  assign ls_new_idx = (ok0 && slot0_in.unit == UNIT_LS) ? cq_tail_r : idx1;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || flush_out) begin
      ls_rs_cnt_r <= 2'h0;
      ls_ea_r <= 1'b0;
      ls_acc_r <= 1'b0;
    end else begin
      if (!(ls_stall_in && ls_acc_r)) ls_acc_r <= ls_ea_r;
      if (ls_ea_take) ls_ea_r <= ls_in || ls_rs_cnt_r != 2'h0;
      // Reservation registers hold loads while the address stage waits
      if (ls_ea_take && ls_rs_cnt_r != 2'h0) begin
        ls_rs_cnt_r <= ls_rs_cnt_r - 2'h1 + {1'b0, ls_in};
      end else if (!ls_ea_take) begin
        ls_rs_cnt_r <= ls_rs_cnt_r + {1'b0, ls_in};
      end
    end
  end
  always_ff @(posedge clk_in) begin
    if (!(ls_stall_in && ls_acc_r)) ls_acc_idx_r <= ls_ea_idx_r;
    if (ls_ea_take) begin
      ls_ea_idx_r <= (ls_rs_cnt_r != 2'h0) ? ls_rs_idx_r[0] : ls_new_idx;
      ls_rs_idx_r[0] <= (ls_rs_cnt_r == 2'h2) ? ls_rs_idx_r[1] : ls_new_idx;
    end else if (ls_in) begin
      ls_rs_idx_r[ls_rs_cnt_r[0]] <= ls_new_idx;
    end
  end
  assign fin_ls = ls_acc_r && !ls_stall_in;

  // ----------------------------------------
  // Exceptions
  // ----------------------------------------
  // halt dispatch to all units; only oldest may signal
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || flush_out) halt_r <= 1'b0;
    else if (exc_in && cq_busy_r[cq_head_r]) halt_r <= 1'b1;
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) flush_out <= 1'b0;
    else flush_out <= exc_in && halt_r && !flush_out;
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      int_done_out <= 1'b0;
      fp_done_out <= 1'b0;
      ls_done_out <= 1'b0;
    end else begin
      int_done_out <= fin_int;
      fp_done_out <= fin_fp;
      ls_done_out <= fin_ls;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_sp_issue;
    fp_free && fp_in0 && !slot0_in.fp_double && !slot0_in.fp_div;
  endsequence
  property p_sp_lat;
    @(posedge clk_in) disable iff (!rst_n_in || flush_out)
      s_sp_issue |-> ##3 fin_fp;
  endproperty
  a_sp_lat: assert property (p_sp_lat)
    else $error("single float latency not three");
  property p_ls_lat;
    @(posedge clk_in) disable iff (!rst_n_in || flush_out)
      ls_in && !ls_acc_r |-> ##2 (ls_acc_r);
  endproperty
  a_ls_lat: assert property (p_ls_lat)
    else $error("load latency not two");
  property p_int_one;
    @(posedge clk_in) disable iff (!rst_n_in || flush_out)
      int_in |=> fin_int;
  endproperty
  a_int_one: assert property (p_int_one)
    else $error("integer not finished in one cycle");
  property p_div_block;
    @(posedge clk_in) disable iff (!rst_n_in)
      fp_mode_r == FP_DIV |-> !fp_in0 && !fp_in1;
  endproperty
  a_div_block: assert property (p_div_block)
    else $error("float issued behind divide");
  property p_halt_block;
    @(posedge clk_in) disable iff (!rst_n_in)
      halt_r |-> !ok0;
  endproperty
  a_halt_block: assert property (p_halt_block)
    else $error("dispatch during exception halt");
  property p_order;
    @(posedge clk_in) disable iff (!rst_n_in)
      ok1 |-> ok0;
  endproperty
  a_order: assert property (p_order)
    else $error("younger issued ahead of older");
  property p_redirect;
    @(posedge clk_in) disable iff (!rst_n_in)
      branch_in.valid && branch_in.taken && !(exc_in && halt_r)
        |=> fetch_pc_out == $past(branch_in.target);
  endproperty
  a_redirect: assert property (p_redirect)
    else $error("fetch not redirected");
  property p_flush_vec;
    @(posedge clk_in) disable iff (!rst_n_in)
      exc_in && halt_r |=> fetch_pc_out == $past(exc_vector_in)
        ##1 cq_cnt_r == 3'h0;
  endproperty
  a_flush_vec: assert property (p_flush_vec)
    else $error("exception did not vector and flush");
endmodule

/* File: rtl/pipe_ctl_map.svh */
// Constants for the superscalar pipeline control block
`ifndef PIPE_CTL_MAP_SVH
`define PIPE_CTL_MAP_SVH
`define CQ_DEPTH 6
`define CQ_PTR_W 3
`define TAG_W 3
`define RB_COUNT 6
`define VEC_W 32
`define FP_LAT_SP 3
`define FP_DP_MUL_CYC 2
`define LSU_RS_COUNT 2
`define PC_RESET 32'h0000_0100
`define PC_STEP 32'h0000_0004
`endif

/* File: rtl/pipe_ctl_pkg.sv */
// Types for the superscalar pipeline control block
package pipe_ctl_pkg;
  typedef enum logic [1:0] {
    UNIT_INT = 2'h0,
    UNIT_FP = 2'h1,
    UNIT_LS = 2'h2,
    UNIT_SYS = 2'h3
  } unit_e;
  typedef enum logic [1:0] {
    FP_IDLE = 2'h0,
    FP_DIV = 2'h1,
    FP_DMUL = 2'h3
  } fp_mode_e;
  typedef struct packed {
    logic valid;
    unit_e unit;
    logic has_dest;
    logic [4:0] dest;
    logic [4:0] src;
    logic is_mul_div;
    logic fp_double;
    logic fp_div;
  } instr_s;
  typedef struct packed {
    logic valid;
    logic writes_cnt_link;
    logic taken;
    logic [31:0] target;
  } branch_s;
  typedef struct packed {
    logic valid;
    unit_e unit;
    logic [2:0] cq_idx;
    logic [2:0] rb_tag;
    logic src_pending;
    logic [2:0] src_tag;
  } issue_s;
endpackage

/* File: verif/iq_feeder.sv */
// Instruction queue model that presents the two oldest entries
`timescale 1ns/10ps
module iq_feeder
  import pipe_ctl_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Dispatch feedback
  input wire logic [1:0] deq_count_in,
  input wire logic flush_in,
  // Two oldest entries
  output pipe_ctl_pkg::instr_s slot0_out,
  output pipe_ctl_pkg::instr_s slot1_out
);
  instr_s q[$];

  task automatic push(input instr_s e);
    q.push_back(e);
  endtask

  // Empty slot shows a changing pattern, so stale fields never look valid
  function automatic instr_s idle_of(input instr_s v);
    instr_s r;
    r = instr_s'(~v);
    r.valid = 1'b0;
    return r;
  endfunction

  initial begin
    slot0_out = '0;
    slot1_out = '0;
  end

  // Pops what the design took at this edge, then shows the next two
  always @(posedge clk_in) begin
    #1;
    if (!rst_n_in || flush_in === 1'b1) begin
      q.delete();
    end else begin
      repeat (deq_count_in) if (q.size() > 0) void'(q.pop_front());
    end
    slot0_out = (q.size() > 0) ? q[0] : idle_of(slot0_out);
    slot1_out = (q.size() > 1) ? q[1] : idle_of(slot1_out);
  end
endmodule

/* File: verif/superscalar_pipeline_control_test.sv */
// Self-checking bench for the pipeline control block
`timescale 1ns/10ps
`include "pipe_ctl_map.svh"
module superscalar_pipeline_control_test;
  import pipe_ctl_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  branch_s branch_in;
  instr_s slot0_in;
  instr_s slot1_in;
  logic fp_div_done_in;
  logic ls_stall_in;
  logic exc_in;
  logic [31:0] exc_vector_in;
  logic [31:0] fetch_pc_out;
  logic branch_folded_out;
  logic [1:0] deq_count_out;
  logic [1:0] retire_count_out;
  issue_s issue0_out;
  issue_s issue1_out;
  logic int_done_out;
  logic fp_done_out;
  logic ls_done_out;
  logic flush_out;
  int fails = 0;
  int check_count = 0;

  always #10 clk_in = ~clk_in;

  pipe_ctl dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .branch_in(branch_in),
    .slot0_in(slot0_in), .slot1_in(slot1_in),
    .fp_div_done_in(fp_div_done_in), .ls_stall_in(ls_stall_in),
    .exc_in(exc_in), .exc_vector_in(exc_vector_in),
    .fetch_pc_out(fetch_pc_out), .branch_folded_out(branch_folded_out),
    .deq_count_out(deq_count_out), .issue0_out(issue0_out),
    .issue1_out(issue1_out), .int_done_out(int_done_out),
    .fp_done_out(fp_done_out), .ls_done_out(ls_done_out),
    .retire_count_out(retire_count_out), .flush_out(flush_out));

  iq_feeder feeder (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .deq_count_in(deq_count_out), .flush_in(flush_out),
    .slot0_out(slot0_in), .slot1_out(slot1_in));

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step();
    @(posedge clk_in);
    #1;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic instr_s mk(input unit_e u, input logic [4:0] d,
                                input logic [4:0] s, input logic dbl);
    return '{1'b1, u, 1'b1, d, s, 1'b0, dbl, 1'b0};
  endfunction

  function automatic logic done_of(input unit_e u);
    case (u)
      UNIT_FP: return fp_done_out;
      UNIT_LS: return ls_done_out;
      default: return int_done_out;
    endcase
  endfunction

  task automatic do_reset();
    rst_n_in = 1'b0;
    branch_in = '0;
    fp_div_done_in = 1'b0;
    ls_stall_in = 1'b0;
    exc_in = 1'b0;
    exc_vector_in = '0;
    repeat (10) step();
    check("reset pc", fetch_pc_out, `PC_RESET);
    check("reset retire", {retire_count_out, deq_count_out, flush_out}, 0);
    rst_n_in = 1'b1;
  endtask

  task automatic wait_issue();
    int n;
    n = 0;
    do begin
      step();
      n++;
    end while (issue0_out.valid !== 1'b1 && n < 10);
    check("issue seen", 32'(n < 10), 1);
  endtask

  // Sums retirements; a lost or doubled retirement shows in the total
  task automatic drain(input int exp);
    int sum;
    sum = 0;
    repeat (8) begin
      step();
      sum += int'(retire_count_out);
    end
    check("retired total", sum, exp);
  endtask

  task automatic t_walk();
    do_reset();
    feeder.push(mk(UNIT_INT, 5'h3, 5'h1, 1'b0));
    wait_issue();
    check("walk deq", deq_count_out, 1);
    check("walk unit", issue0_out.unit, UNIT_INT);
    check("walk slot1", issue1_out.valid, 0);
    step();
    check("walk int done", int_done_out, 1);
    step();
    check("walk retire", retire_count_out, 1);
  endtask

  task automatic t_dual();
    do_reset();
    feeder.push(mk(UNIT_INT, 5'h3, 5'h1, 1'b0));
    feeder.push(mk(UNIT_LS, 5'h4, 5'h3, 1'b0));
    wait_issue();
    check("dual deq", deq_count_out, 2);
    check("dual unit", issue1_out.unit, UNIT_LS);
    check("dual order", issue1_out.cq_idx, 3'(issue0_out.cq_idx + 1));
    check("dual pending", issue1_out.src_pending, 1);
    check("dual tag", issue1_out.src_tag, issue0_out.rb_tag);
    check("dual rename", 32'(issue1_out.rb_tag != issue0_out.rb_tag), 1);
    drain(2);
  endtask

  task automatic t_refuse();
    logic [2:0] idx;
    do_reset();
    feeder.push(mk(UNIT_INT, 5'h3, 5'h1, 1'b0));
    feeder.push(mk(UNIT_INT, 5'h5, 5'h2, 1'b0));
    wait_issue();
    idx = issue0_out.cq_idx;
    check("refuse deq", deq_count_out, 1);
    check("refuse slot1", issue1_out.valid, 0);
    step();
    check("refuse retry", issue0_out.valid, 1);
    check("refuse order", issue0_out.cq_idx, 3'(idx + 1));
    drain(2);
  endtask

  task automatic t_lat(input instr_s a, input int exp);
    int n;
    do_reset();
    feeder.push(a);
    wait_issue();
    n = 0;
    while (done_of(a.unit) !== 1'b1 && n < 12) begin
      step();
      n++;
    end
    check("latency", n, exp);
  endtask

  task automatic t_gap(input instr_s a, input int exp);
    int n;
    do_reset();
    feeder.push(a);
    feeder.push(a);
    n = 0;
    while (fp_done_out !== 1'b1 && n < 20) begin
      step();
      n++;
    end
    n = 0;
    do begin
      step();
      n++;
    end while (fp_done_out !== 1'b1 && n < 12);
    check("throughput", n, exp);
  endtask

  // Divide holds the first float stage; a younger float op waits behind it
  task automatic t_div();
    instr_s d;
    int n;
    d = mk(UNIT_FP, 5'h9, 5'h1, 1'b0);
    d.fp_div = 1'b1;
    do_reset();
    feeder.push(d);
    feeder.push(mk(UNIT_FP, 5'ha, 5'h2, 1'b0));
    wait_issue();
    repeat (5) begin
      step();
      check("div hold", fp_done_out, 0);
      check("div younger", issue0_out.valid, 0);
    end
    fp_div_done_in = 1'b1;
    step();
    fp_div_done_in = 1'b0;
    n = 0;
    while (fp_done_out !== 1'b1 && n < 12) begin
      step();
      n++;
    end
    check("div finish", n, `FP_LAT_SP);
    drain(2);
  endtask

  task automatic t_branch();
    int folds;
    logic hit;
    for (int i = 0; i < 3; i++) begin
      do_reset();
      branch_in = '{1'b1, i == 2, i != 1, 32'h0000_8000};
      step();
      branch_in.valid = 1'b0;
      folds = int'(branch_folded_out);
      hit = (fetch_pc_out === 32'h0000_8000);
      repeat (4) begin
        step();
        folds += int'(branch_folded_out);
        hit |= (fetch_pc_out === 32'h0000_8000);
      end
      check("branch fold", folds, 32'(i != 2));
      check("branch redirect", hit, 32'(i != 1));
    end
  endtask

  task automatic t_exc();
    logic seen;
    logic hit;
    do_reset();
    ls_stall_in = 1'b1;
    feeder.push(mk(UNIT_LS, 5'h6, 5'h2, 1'b0));
    wait_issue();
    repeat (4) begin
      step();
      check("stall holds", ls_done_out, 0);
    end
    exc_vector_in = 32'h0000_0700;
    exc_in = 1'b1;
    seen = 1'b0;
    hit = 1'b0;
    repeat (8) begin
      step();
      seen |= (flush_out === 1'b1);
      hit |= (fetch_pc_out === 32'h0000_0700);
      if (seen) exc_in = 1'b0;
    end
    check("exc flush", seen, 1);
    check("exc vector", hit, 1);
    ls_stall_in = 1'b0;
    drain(0);
  endtask

  // Roughly 250 cycles of work; the limit leaves a wide margin
  initial begin
    #200000;
    fails++;
    give_verdict();
  end

  initial begin
    do_reset();
    t_walk();
    t_dual();
    t_refuse();
    t_lat(mk(UNIT_FP, 5'h7, 5'h1, 1'b0), `FP_LAT_SP);
    t_lat(mk(UNIT_FP, 5'h7, 5'h1, 1'b1), 4);
    t_lat(mk(UNIT_LS, 5'h7, 5'h1, 1'b0), 2);
    t_gap(mk(UNIT_FP, 5'h8, 5'h1, 1'b0), 1);
    t_gap(mk(UNIT_FP, 5'h8, 5'h1, 1'b1), `FP_DP_MUL_CYC);
    t_div();
    t_branch();
    t_exc();
    give_verdict();
  end
endmodule
